//--- nsep_top.v
// nand sector ecc parity report block with wishbone slave
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "nsep_consts.vh"
module nsep_top (
	input wire core_clk,
	input wire rstn,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire wb_we_i,
	input wire [3:0] wb_sel_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire data_valid,
	input wire [7:0] data_byte,
	input wire ref_valid,
	input wire [3:0] ref_index,
	input wire [23:0] ref_parity,
	output reg irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_FIN = 2'h2;
	reg [1:0] state;
	reg [31:0] ctrl;
	reg [`NSEP_STATUS_W-1:0] status;
	reg [`NSEP_STATUS_W-1:0] irq_mask;
	reg [15:0] err_flags;
	reg [12:0] byte_cnt;
	reg [12:0] page_len;
	reg mode512;
	wire [23:0] sec_par [0:`NSEP_NUM_RES-1];
	wire [1:0] sec_kind [0:`NSEP_NUM_RES-1];
	wire [2:0] sec_bit [0:`NSEP_NUM_RES-1];
	wire [8:0] sec_byte [0:`NSEP_NUM_RES-1];
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function [12:0] page_bytes;
		input [1:0] code;
		begin
			case (code)
				`NSEP_PS_512: page_bytes = 13'h0200;
				`NSEP_PS_2048: page_bytes = 13'h0800;
				default: page_bytes = 13'h1000;
			endcase
		end
	endfunction
	// sector index for a byte offset; 512 mode uses doubled sectors
	function [3:0] sec_of;
		input [12:0] ofs;
		input m512;
		begin
			if (m512) begin
				sec_of = {1'b0, ofs[11:`NSEP_SEC512_SHIFT]};
			end else begin
				sec_of = ofs[11:`NSEP_SEC256_SHIFT];
			end
		end
	endfunction
	// result word: bits 11 and 23 forced zero, 31:24 zero
	function [31:0] pack_res;
		input [23:0] p;
		input [2:0] b;
		input [7:0] w;
		begin
			pack_res = 32'h00000000;
			pack_res[`NSEP_BIT_MSB:`NSEP_BIT_LSB] = b;
			pack_res[`NSEP_WORD_MSB:`NSEP_WORD_LSB] = w;
			pack_res[`NSEP_PAR_MSB:`NSEP_PAR_LSB] = p[22:12];
		end
	endfunction
	wire [3:0] cur_sec = sec_of(byte_cnt, mode512);
	wire run = (state == ST_RUN);
	wire go = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = go && wb_we_i;
	wire [3:0] res_idx = wb_adr_i[5:2];
	wire res_hit = (wb_adr_i >= `NSEP_OFS_RES_BASE) && (wb_adr_i[7:6] == 2'h0);
	// ------------------------------------------------------------
	// per-sector accumulators
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `NSEP_NUM_RES; g = g + 1) begin : gsec
			wire [8:0] idx = mode512 ? byte_cnt[8:0] : {1'b0, byte_cnt[7:0]};
			nsep_sector_ecc u_sec (
				.core_clk(core_clk),
				.rstn(rstn),
				.clear(state == ST_IDLE && wr && wb_adr_i == `NSEP_OFS_CTRL
					&& wb_dat_i[`NSEP_CTRL_START]),
				.byte_en(run && data_valid && cur_sec == g),
				.byte_idx(idx),
				.data(data_byte),
				.ld_ref(ref_valid && !ctrl[`NSEP_CTRL_WRITE] && ref_index == g),
				.ref_par(ref_parity),
				.par(sec_par[g]),
				.err_kind(sec_kind[g]),
				.bit_pos(sec_bit[g]),
				.byte_addr(sec_byte[g])
			);
		end
	endgenerate
	// ------------------------------------------------------------
	// page sequencer
	// ------------------------------------------------------------
	reg any_single;
	reg any_multi;
	reg [15:0] multi_vec;
	integer k;
	always @* begin
		any_single = 1'b0;
		any_multi = 1'b0;
		multi_vec = 16'h0000;
		for (k = 0; k < `NSEP_NUM_RES; k = k + 1) begin
			if (sec_kind[k] == 2'h1) begin
				any_single = 1'b1;
			end
			if (sec_kind[k] == 2'h2) begin
				any_multi = 1'b1;
				multi_vec[k] = 1'b1;
			end
		end
	end
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			byte_cnt <= 13'h0000;
			page_len <= 13'h0200;
			mode512 <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (wr && wb_adr_i == `NSEP_OFS_CTRL && wb_dat_i[`NSEP_CTRL_START]) begin
						state <= ST_RUN;
						byte_cnt <= 13'h0000;
						mode512 <= wb_dat_i[`NSEP_CTRL_MODE512];
						page_len <= page_bytes(wb_dat_i[`NSEP_CTRL_PSIZE_MSB:`NSEP_CTRL_PSIZE_LSB]);
					end
				end
				ST_RUN: begin
					if (data_valid) begin
						byte_cnt <= byte_cnt + 13'h0001;
						if (byte_cnt == page_len - 13'h0001) begin
							state <= ST_FIN;
						end
					end
				end
				ST_FIN: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// control, status, mask and interrupt
	// ------------------------------------------------------------
	reg [`NSEP_STATUS_W-1:0] events;
	always @* begin
		events = {`NSEP_STATUS_W{1'b0}};
		if (state == ST_FIN) begin
			events[`NSEP_ST_DONE] = 1'b1;
			events[`NSEP_ST_SINGLE] = any_single && !ctrl[`NSEP_CTRL_WRITE];
			events[`NSEP_ST_MULTI] = any_multi && !ctrl[`NSEP_CTRL_WRITE];
		end
	end
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `NSEP_CTRL_RESET;
			status <= {`NSEP_STATUS_W{1'b0}};
			irq_mask <= {`NSEP_STATUS_W{1'b0}};
			err_flags <= 16'h0000;
			irq <= 1'b0;
		end else begin
			if (wr && wb_adr_i == `NSEP_OFS_CTRL && wb_sel_i[0]) begin
				ctrl <= {26'h0, wb_dat_i[5:4], 1'b0, wb_dat_i[2], 1'b0, wb_dat_i[0]};
			end
			if (wr && wb_adr_i == `NSEP_OFS_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask <= wb_dat_i[`NSEP_STATUS_W-1:0];
			end
			// set wins over write-one-to-clear
			if (wr && wb_adr_i == `NSEP_OFS_STATUS && wb_sel_i[0]) begin
				status <= (status & ~wb_dat_i[`NSEP_STATUS_W-1:0]) | events;
			end else begin
				status <= status | events;
			end
			if (state == ST_FIN) begin
				err_flags <= multi_vec;
			end
			irq <= |((status | events) & irq_mask);
		end
	end
	// ------------------------------------------------------------
	// wishbone read path, one wait state: ack the cycle after stb
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= go;
			wb_dat_o <= 32'h00000000;
			if (go && !wb_we_i) begin
				if (wb_adr_i == `NSEP_OFS_CTRL) begin
					wb_dat_o <= ctrl;
				end else if (wb_adr_i == `NSEP_OFS_STATUS) begin
					wb_dat_o <= {29'h0, status};
				end else if (wb_adr_i == `NSEP_OFS_IRQ_MASK) begin
					wb_dat_o <= {29'h0, irq_mask};
				end else if (wb_adr_i == `NSEP_OFS_ERR_FLAGS) begin
					wb_dat_o <= {16'h0, err_flags};
				end else if (res_hit) begin
					// 512 mode keeps full 9-bit byte address; 8 bits shown
					wb_dat_o <= pack_res(sec_par[res_idx - 4'h4], sec_bit[res_idx - 4'h4],
						sec_byte[res_idx - 4'h4][7:0]);
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- nsep_consts.vh
// constants for the nand sector ecc parity report block
`ifndef NSEP_CONSTS_VH
`define NSEP_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define NSEP_OFS_CTRL 8'h00
`define NSEP_OFS_STATUS 8'h04
`define NSEP_OFS_IRQ_MASK 8'h08
`define NSEP_OFS_ERR_FLAGS 8'h0C
`define NSEP_OFS_RES_BASE 8'h10
// ------------------------------------------------------------
// result field positions
// ------------------------------------------------------------
`define NSEP_BIT_LSB 0
`define NSEP_BIT_MSB 2
`define NSEP_WORD_LSB 3
`define NSEP_WORD_MSB 10
`define NSEP_PAR_LSB 12
`define NSEP_PAR_MSB 22
// ------------------------------------------------------------
// control and status bits
// ------------------------------------------------------------
`define NSEP_CTRL_MODE512 0
`define NSEP_CTRL_START 1
`define NSEP_CTRL_WRITE 2
`define NSEP_CTRL_PSIZE_LSB 4
`define NSEP_CTRL_PSIZE_MSB 5
`define NSEP_ST_DONE 0
`define NSEP_ST_SINGLE 1
`define NSEP_ST_MULTI 2
`define NSEP_STATUS_W 3
// ------------------------------------------------------------
// page size codes and sizes
// ------------------------------------------------------------
`define NSEP_PS_512 2'h0
`define NSEP_PS_2048 2'h1
`define NSEP_PS_4096 2'h2
`define NSEP_SEC256_SHIFT 8
`define NSEP_SEC512_SHIFT 9
`define NSEP_NUM_RES 16
`define NSEP_SEC7_512 3'h7
`define NSEP_CTRL_RESET 32'h00000000
`endif

//--- nsep_sector_ecc.v
// one sector's hamming accumulator and syndrome decoder
`timescale 1ns/1ps
`default_nettype none
module nsep_sector_ecc (
	input wire core_clk,
	input wire rstn,
	input wire clear,
	input wire byte_en,
	input wire [8:0] byte_idx,
	input wire [7:0] data,
	input wire ld_ref,
	input wire [23:0] ref_par,
	output reg [23:0] par,
	output wire [1:0] err_kind,
	output wire [2:0] bit_pos,
	output wire [8:0] byte_addr
);
	// ------------------------------------------------------------
	// accumulation: low 12 bits xor bit index where bit set,
	// high 12 bits xor inverted index, the classic pairing
	// ------------------------------------------------------------
	reg [11:0] acc_p;
	reg [11:0] acc_n;
	integer i;
	always @* begin
		acc_p = par[11:0];
		acc_n = par[23:12];
		for (i = 0; i < 8; i = i + 1) begin
			if (data[i]) begin
				acc_p = acc_p ^ {byte_idx, i[2:0]};
				acc_n = acc_n ^ ~{byte_idx, i[2:0]};
			end
		end
	end
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			par <= 24'h000000;
		end else if (clear) begin
			par <= 24'h000000;
		end else if (ld_ref) begin
			par <= par ^ ref_par;
		end else if (byte_en) begin
			par <= {acc_n, acc_p};
		end
	end
	// ------------------------------------------------------------
	// decode: zero = clean, halves complementary = single bit
	// ------------------------------------------------------------
	wire single = (par[11:0] == ~par[23:12]);
	assign err_kind = (par == 24'h000000) ? 2'h0 : (single ? 2'h1 : 2'h2);
	assign bit_pos = par[2:0];
	assign byte_addr = par[11:3];
endmodule
`default_nettype wire

//--- nsep_top_sva.sv
// bus timing and result layout checker for the sector ecc report block
`timescale 1ns/1ps
`default_nettype none
module nsep_top_chk (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// -------------------------------------------
	// bus cycle steps
	// -------------------------------------------
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd_s;
		wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
	endsequence
	sequence res_rd_s;
		rd_s ##0 (wb_adr_i >= 8'h10 && wb_adr_i <= 8'h3C);
	endsequence
	ack_delay_a: assert property (req_s |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	no_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	res_hi_a: assert property (res_rd_s |-> wb_dat_o[31:23] == 9'h000)
		else $error("result upper bits not zero");
	res_gap_a: assert property (res_rd_s |-> !wb_dat_o[11])
		else $error("result bit 11 not zero");
	unmap_zero_a: assert property (rd_s ##0 wb_adr_i >= 8'h40 |-> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
endmodule
bind nsep_top nsep_top_chk u_nsep_top_chk (.core_clk, .rstn, .wb_adr_i, .wb_we_i, .wb_cyc_i,
	.wb_stb_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

//--- test_nsep_top.sv
// self-checking bench for the sector ecc report block
`timescale 1ns/1ps
`default_nettype none
module test_nsep_top;
	logic core_clk, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, data_valid, irq;
	logic [7:0] wb_adr_i, data_byte;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	integer err_count = 0, check_count = 0, cyc_n = 0;
	// parity reference path is left idle: an all-zero page needs no stored check
	nsep_top u_nsep_top (.core_clk, .rstn, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .data_valid, .data_byte,
		.ref_valid(1'h0), .ref_index(4'h0), .ref_parity(24'h000000), .irq);
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 30000) begin
			err_count = err_count + 1;
			wrap_up;
		end
	end
	// -------------------------------------------
	// shared tasks
	// -------------------------------------------
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g, input string what);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				$display("MISMATCH %s expected %h seen %h", what, e, g);
				err_count = err_count + 1;
			end
		end
	endtask
	// waits for ack with no assumed latency; only the bench timeout ends it
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		begin
			wb_cyc_i <= 1'h1; wb_stb_i <= 1'h1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
			do @(posedge core_clk); while (wb_ack_o !== 1'h1);
			r = wb_dat_o;
			wb_cyc_i <= 1'h0; wb_stb_i <= 1'h0; wb_we_i <= 1'h0;
			@(posedge core_clk);
		end
	endtask
	task page(input logic m, input logic [1:0] ps, input integer len, input integer eb,
		input logic [2:0] bp);
		integer i;
		begin
			wb(1'h1, 8'h04, 32'h00000007, q);
			wb(1'h1, 8'h00, {26'h0000000, ps, 2'h0, 1'h1, m}, q);
			for (i = 0; i < len; i++) begin
				data_valid <= 1'h1;
				data_byte <= (i == eb) ? (8'h01 << bp) : 8'h00;
				@(posedge core_clk);
			end
			data_valid <= 1'h0;
			i = 0;
			q = 32'h00000000;
			while (q[0] !== 1'h1 && i < 20) begin
				wb(1'h0, 8'h04, 32'h00000000, q);
				i++;
			end
			chk(32'h00000003, q, "status");
		end
	endtask
	// parity field is masked out: only location and zero bits are predictable
	task res(input integer idx, input integer eb, input logic [2:0] bp);
		begin
			wb(1'h0, 8'(8'h10 + 4 * idx), 32'h00000000, q);
			chk({21'h000000, eb[7:0], bp}, q & 32'hFF800FFF, "result");
		end
	endtask
	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	task t_pages;
		begin
			page(1'h0, 2'h0, 512, 300, 3'h5);
			res(1, 300, 3'h5);
			page(1'h0, 2'h1, 2048, 1100, 3'h0);
			res(4, 1100, 3'h0);
			page(1'h0, 2'h2, 4096, 700, 3'h7);
			res(2, 700, 3'h7);
			page(1'h1, 2'h2, 4096, 4035, 3'h2);
			res(7, 4035, 3'h2);
		end
	endtask
	// two flipped bits in sector 0: status must flag multi, not single
	task t_multi;
		integer i;
		begin
			wb(1'h1, 8'h04, 32'h00000007, q);
			wb(1'h1, 8'h00, 32'h00000002, q);
			for (i = 0; i < 512; i++) begin
				data_valid <= 1'h1;
				data_byte <= (i == 10) ? 8'h01 : ((i == 20) ? 8'h02 : 8'h00);
				@(posedge core_clk);
			end
			data_valid <= 1'h0;
			repeat (3) @(posedge core_clk);
			wb(1'h0, 8'h04, 32'h00000000, q);
			chk(32'h00000005, q, "multi status");
			wb(1'h0, 8'h0C, 32'h00000000, q);
			chk(32'h00000001, q, "multi flags");
		end
	endtask
	task t_regs;
		begin
			wb(1'h1, 8'h2C, 32'hFFFFFFFF, q);
			res(7, 4035, 3'h2);
			wb(1'h0, 8'h80, 32'h00000000, q);
			chk(32'h00000000, q, "unmapped");
		end
	endtask
	task t_irq;
		begin
			chk(32'h00000000, {31'h0, irq}, "irq masked");
			wb(1'h1, 8'h08, 32'h00000001, q);
			repeat (2) @(posedge core_clk);
			chk(32'h00000001, {31'h0, irq}, "irq raised");
			wb(1'h1, 8'h04, 32'h00000007, q);
			repeat (2) @(posedge core_clk);
			chk(32'h00000000, {31'h0, irq}, "irq cleared");
			wb(1'h0, 8'h04, 32'h00000000, q);
			chk(32'h00000000, q, "status cleared");
		end
	endtask
	initial begin
		rstn = 1'h0; wb_cyc_i = 1'h0; wb_stb_i = 1'h0; wb_we_i = 1'h0; wb_adr_i = 8'h00;
		wb_dat_i = 32'h00000000; wb_sel_i = 4'hF; data_valid = 1'h0; data_byte = 8'h00;
		repeat (6) @(posedge core_clk);
		rstn <= 1'h1;
		@(posedge core_clk);
		t_pages;
		t_regs;
		t_multi;
		t_irq;
		wrap_up;
	end
endmodule
`default_nettype wire
